// ==== uif_dev_end.sv ====
// Function
// - Enabled flags ORed into one interrupt line
// - Flags stay set until written one
// - Flags and enables reset to zero
// - Stall flag on STALL handshake sent
// - Resume flag after K held 2.5 us
// - Firmware enables resume only before suspend
// - Sleep flag after 3 ms idle
// - Any bus activity restarts sleep timer
// - Transaction done flag on transaction end
// - Clearing done flag pops status pulse
// - Firmware reads status before clearing done
// - Frame start flag on SOF token
// - Error flag from error status register
// - Bus reset flag after 2.5 us reset
// - Bus reset flag rearms after reset removed
// - Firmware clears address, enables endpoint zero; fw end only latches o_bus_reset_seen
// - Enable bit unmasks same flag position
// - Enabled error bits ORed into error flag
`timescale 1ns/10ps
`default_nettype none
module uif_dev_end (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   uif_if.dev bus,
   input wire logic i_stall_sent,
   input wire logic i_k_state,
   input wire logic i_bus_idle,
   input wire logic i_se0_reset,
   input wire logic i_txn_done,
   input wire logic i_sof_token,
   input wire logic [7:0] i_err_events,
   output logic o_status_pop
);
   logic [7:0] flags_reg, flags_next;
   logic [7:0] en_reg;
   logic [7:0] err_reg, err_next;
   logic [7:0] err_en_reg;
   logic [7:0] rdata_reg;
   logic [uif_pkg::CNT_W-1:0] k_cnt_reg, idle_cnt_reg, rst_cnt_reg;
   logic resume_hit_reg, sleep_hit_reg, rst_done_reg;
   logic [1:0] k_sync_reg, idle_sync_reg, rst_sync_reg;
   logic k_s, idle_s, rst_s;
   logic resume_ev, sleep_ev, busrst_ev;
   logic [7:0] set_vec, clr_vec, err_clr;
   logic wr_flags, wr_en, wr_err, wr_err_en;
   logic [7:0] rdata_next_v;
   // Write strobe aimed at one register index
   function automatic logic uif_wr_hit(input logic wr, input logic [1:0] addr, input logic [1:0] idx);
      return wr && (addr == idx);
   endfunction
   // Pin-side levels after two flops
   assign k_s = k_sync_reg[1];
   assign idle_s = idle_sync_reg[1];
   assign rst_s = rst_sync_reg[1];
   // Register write decode
   assign wr_flags = uif_wr_hit(bus.wr, bus.addr, uif_pkg::ADDR_FLAGS);
   assign wr_en = uif_wr_hit(bus.wr, bus.addr, uif_pkg::ADDR_ENABLES);
   assign wr_err = uif_wr_hit(bus.wr, bus.addr, uif_pkg::ADDR_ERR_FLAGS);
   assign wr_err_en = uif_wr_hit(bus.wr, bus.addr, uif_pkg::ADDR_ERR_ENABLES);
   assign clr_vec = wr_flags ? bus.wdata : 8'h00;
   assign err_clr = wr_err ? bus.wdata : 8'h00;
   // Timer events, one cycle at threshold
   assign resume_ev = k_s && !resume_hit_reg && (k_cnt_reg == uif_pkg::CNT_W'(uif_pkg::RESUME_CYCLES - 1));
   assign sleep_ev = idle_s && !sleep_hit_reg && (idle_cnt_reg == uif_pkg::CNT_W'(uif_pkg::SLEEP_CYCLES - 1));
   assign busrst_ev = rst_s && !rst_done_reg && (rst_cnt_reg == uif_pkg::CNT_W'(uif_pkg::BUSRST_CYCLES - 1));
   // Event set vector
   always_comb begin
      set_vec = 8'h00;
      set_vec[uif_pkg::BIT_STALL] = i_stall_sent;
      set_vec[uif_pkg::BIT_RESUME] = resume_ev;
      set_vec[uif_pkg::BIT_SLEEP] = sleep_ev;
      set_vec[uif_pkg::BIT_TOKDONE] = i_txn_done;
      set_vec[uif_pkg::BIT_SOF] = i_sof_token;
      set_vec[uif_pkg::BIT_ERROR] = |(err_reg & err_en_reg);
      set_vec[uif_pkg::BIT_BUSRST] = busrst_ev;
   end
   // Set wins over clear, bit 6 never stored
   assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & uif_pkg::FLAG_MASK;
   assign err_next = ((err_reg & ~err_clr) | i_err_events) & uif_pkg::ERR_MASK;
   assign bus.irq = |(flags_reg & en_reg);
   assign bus.rdata = rdata_reg;
   // Read data mux
   always_comb begin
      unique case (bus.addr)
         uif_pkg::ADDR_FLAGS: rdata_next_v = flags_reg;
         uif_pkg::ADDR_ENABLES: rdata_next_v = en_reg;
         uif_pkg::ADDR_ERR_FLAGS: rdata_next_v = err_reg;
         uif_pkg::ADDR_ERR_ENABLES: rdata_next_v = err_en_reg;
      endcase
   end
   // Flags, enables, status pop
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         flags_reg <= uif_pkg::RESET_VAL;
         en_reg <= uif_pkg::RESET_VAL;
         err_reg <= uif_pkg::RESET_VAL;
         err_en_reg <= uif_pkg::RESET_VAL;
         rdata_reg <= uif_pkg::RESET_VAL;
         o_status_pop <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         err_reg <= err_next;
         if (wr_en) en_reg <= bus.wdata & uif_pkg::FLAG_MASK;
         if (wr_err_en) err_en_reg <= bus.wdata & uif_pkg::ERR_MASK;
         rdata_reg <= rdata_next_v;
         o_status_pop <= clr_vec[uif_pkg::BIT_TOKDONE];
      end
   end
   // Pin synchronisers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         k_sync_reg <= 2'h0;
         idle_sync_reg <= 2'h0;
         rst_sync_reg <= 2'h0;
      end else begin
         k_sync_reg <= {k_sync_reg[0], i_k_state};
         idle_sync_reg <= {idle_sync_reg[0], i_bus_idle};
         rst_sync_reg <= {rst_sync_reg[0], i_se0_reset};
      end
   end
   // Duration timers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         k_cnt_reg <= '0;
         idle_cnt_reg <= '0;
         rst_cnt_reg <= '0;
         resume_hit_reg <= 1'b0;
         sleep_hit_reg <= 1'b0;
         rst_done_reg <= 1'b0;
      end else begin
         k_cnt_reg <= (k_s && !resume_hit_reg) ? k_cnt_reg + 1'b1 : '0;
         resume_hit_reg <= k_s && (resume_hit_reg || resume_ev);
         idle_cnt_reg <= (idle_s && !sleep_hit_reg) ? idle_cnt_reg + 1'b1 : '0;
         sleep_hit_reg <= idle_s && (sleep_hit_reg || sleep_ev);
         rst_cnt_reg <= (rst_s && !rst_done_reg) ? rst_cnt_reg + 1'b1 : '0;
         rst_done_reg <= rst_s && (rst_done_reg || busrst_ev);
      end
   end
endmodule
`default_nettype wire

// ==== uif_pkg.sv ====
package uif_pkg;
   // Register indices (no offsets printed)
   localparam logic [1:0] ADDR_FLAGS = 2'h0;
   localparam logic [1:0] ADDR_ENABLES = 2'h1;
   localparam logic [1:0] ADDR_ERR_FLAGS = 2'h2;
   localparam logic [1:0] ADDR_ERR_ENABLES = 2'h3;
   // Flag bit positions
   localparam int BIT_STALL = 7;
   localparam int BIT_RESUME = 5;
   localparam int BIT_SLEEP = 4;
   localparam int BIT_TOKDONE = 3;
   localparam int BIT_SOF = 2;
   localparam int BIT_ERROR = 1;
   localparam int BIT_BUSRST = 0;
   localparam logic [7:0] FLAG_MASK = 8'hbf;
   localparam logic [7:0] ERR_MASK = 8'hbf;
   localparam logic [7:0] RESET_VAL = 8'h00;
   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RESUME_TIME_PS = 2500000;
   localparam int BUSRST_TIME_PS = 2500000;
   localparam int SLEEP_TIME_US = 3000;
   localparam int RESUME_CYCLES = (RESUME_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BUSRST_CYCLES = (BUSRST_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Cycles per microsecond first, so the product stays inside a 32-bit int
   localparam int SLEEP_CYCLES = SLEEP_TIME_US * (1000000 / CLK_PERIOD_PS);
   localparam int CNT_W = 20;
   // Firmware states
   typedef enum logic [3:0] {
      FW_IDLE = 4'b0001,
      FW_READ = 4'b0010,
      FW_EVAL = 4'b0100,
      FW_CLEAR = 4'b1000
   } uif_fw_state_t;
endpackage

// ==== uif_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface uif_if;
   logic wr;
   logic rd;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic irq;
   modport dev (input wr, input rd, input addr, input wdata, output rdata, output irq);
   modport fw (output wr, output rd, output addr, output wdata, input rdata, input irq);
endinterface
`default_nettype wire

// ==== uif_fw_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module uif_fw_end (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   uif_if.fw bus,
   input wire logic [7:0] i_enables,
   input wire logic i_apply,
   output logic [7:0] o_last_flags,
   output logic o_bus_reset_seen,
   output logic o_busy
);
   uif_pkg::uif_fw_state_t state_reg, state_next;
   logic [7:0] flags_reg;
   logic [7:0] en_reg;
   logic apply_reg;
   logic rst_seen_reg;
   // Bus drive from state
   assign bus.rd = (state_reg == uif_pkg::FW_READ);
   assign bus.wr = apply_reg || (state_reg == uif_pkg::FW_CLEAR);
   assign bus.addr = apply_reg ? uif_pkg::ADDR_ENABLES : uif_pkg::ADDR_FLAGS;
   assign bus.wdata = apply_reg ? en_reg : flags_reg;
   assign o_last_flags = flags_reg;
   assign o_bus_reset_seen = rst_seen_reg;
   assign o_busy = (state_reg != uif_pkg::FW_IDLE);
   // Service sequence: read, then clear what was read
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         uif_pkg::FW_IDLE: if (bus.irq && !apply_reg) state_next = uif_pkg::FW_READ;
         uif_pkg::FW_READ: state_next = uif_pkg::FW_EVAL;
         uif_pkg::FW_EVAL: state_next = uif_pkg::FW_CLEAR;
         uif_pkg::FW_CLEAR: state_next = uif_pkg::FW_IDLE;
      endcase
   end
   // Registers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_reg <= uif_pkg::FW_IDLE;
         flags_reg <= uif_pkg::RESET_VAL;
         en_reg <= uif_pkg::RESET_VAL;
         apply_reg <= 1'b0;
         rst_seen_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         apply_reg <= i_apply && (state_reg == uif_pkg::FW_IDLE);
         if (i_apply) en_reg <= i_enables;
         if (state_reg == uif_pkg::FW_READ) flags_reg <= bus.rdata;
         // Bus reset seen: latched only, nothing clears an address or enables endpoint 0
         if (state_reg == uif_pkg::FW_EVAL && flags_reg[uif_pkg::BIT_BUSRST]) rst_seen_reg <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== uif_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module uif_chk (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // Register bus relations
   a_reset_all_zero:
      assert property ($fell(i_sys_rst) |-> rdata == 8'h00 && !irq) else $error("nonzero after reset");
   a_unused_bit_zero:
      assert property (rdata[6] == 1'b0) else $error("bit 6 read as one");
   a_enable_readback:
      assert property (wr && addr == uif_pkg::ADDR_ENABLES ##1 !wr && addr == uif_pkg::ADDR_ENABLES
         |=> rdata == ($past(wdata, 2) & uif_pkg::FLAG_MASK)) else $error("enable readback wrong");
   a_flags_sticky:
      assert property (addr == uif_pkg::ADDR_FLAGS && $past(addr) == uif_pkg::ADDR_FLAGS && !$past(wr)
         |=> (rdata & $past(rdata)) == $past(rdata)) else $error("flag dropped without write");
   a_irq_masked:
      assert property ($past(addr) == uif_pkg::ADDR_ENABLES && !$past(wr) && rdata == 8'h00 |-> !irq)
         else $error("irq with all enables off");
   a_irq_drop_write:
      assert property ($fell(irq) |-> $past(wr)) else $error("irq dropped without a write");
   // Main scenarios
   cover property (wr && addr == uif_pkg::ADDR_FLAGS);
   cover property (wr && addr == uif_pkg::ADDR_ENABLES);
   cover property ($rose(irq));
   cover property (rd ##1 wr);
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [2:0] ev = 3'h0;
   logic [7:0] err = 8'h00;
   logic k_st = 1'b0;
   logic se0 = 1'b0;
   logic apply = 1'b0;
   logic pop;
   logic seen;
   logic [7:0] exp_flag [3] = '{8'h80, 8'h08, 8'h04};
   int bad_count = 0;
   int compares = 0;
   uif_if bus_a ();
   uif_if bus_b ();
   // Clock
   always #2 i_mclk = ~i_mclk;
   // Both ends on bus_a, bench drives bus_b
   uif_dev_end i_uif_dev_end (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_a), .i_stall_sent(ev[2]),
      .i_k_state(k_st), .i_bus_idle(1'b0), .i_se0_reset(se0), .i_txn_done(ev[1]), .i_sof_token(ev[0]),
      .i_err_events(err), .o_status_pop());
   uif_dev_end i_uif_dev_end_b (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_b), .i_stall_sent(ev[2]),
      .i_k_state(k_st), .i_bus_idle(1'b0), .i_se0_reset(se0), .i_txn_done(ev[1]), .i_sof_token(ev[0]),
      .i_err_events(err), .o_status_pop(pop));
   uif_fw_end i_uif_fw_end (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_a), .i_enables(8'hff),
      .i_apply(apply), .o_last_flags(), .o_bus_reset_seen(seen), .o_busy());
   uif_chk i_uif_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .wr(bus_a.wr), .rd(bus_a.rd),
      .addr(bus_a.addr), .wdata(bus_a.wdata), .rdata(bus_a.rdata), .irq(bus_a.irq));
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hold(input int n);
      repeat (n) @(negedge i_mclk);
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      bus_b.wr = 1'b1;
      bus_b.addr = a;
      bus_b.wdata = d;
      @(negedge i_mclk);
      bus_b.wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
      @(negedge i_mclk);
      bus_b.addr = a;
      @(negedge i_mclk);
      check($sformatf("reg%0d", a), bus_b.rdata, exp);
   endtask
   task automatic pulse(input logic [10:0] v);
      @(negedge i_mclk);
      {ev, err} = v;
      @(negedge i_mclk);
      {ev, err} = 11'h000;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      hold(20000);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      bus_b.wr = 1'b0;
      bus_b.rd = 1'b0;
      bus_b.addr = 2'h0;
      bus_b.wdata = 8'h00;
      hold(2);
      i_sys_rst = 1'b0;
      apply = 1'b1;
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      apply = 1'b0;
      rd_reg(uif_pkg::ADDR_ENABLES, 8'h00);
      pulse(11'h100);
      check("masked irq", {7'h00, bus_b.irq}, 8'h00);
      wr_reg(uif_pkg::ADDR_FLAGS, 8'h04);
      wr_reg(uif_pkg::ADDR_ENABLES, 8'hff);
      rd_reg(uif_pkg::ADDR_ENABLES, 8'hbf);
      for (int i = 0; i < 3; i++) begin
         pulse({3'h4 >> i, 8'h00});
         rd_reg(uif_pkg::ADDR_FLAGS, exp_flag[i]);
         check("irq", {7'h00, bus_b.irq}, 8'h01);
         wr_reg(uif_pkg::ADDR_FLAGS, 8'h00);
         rd_reg(uif_pkg::ADDR_FLAGS, exp_flag[i]);
         wr_reg(uif_pkg::ADDR_FLAGS, exp_flag[i]);
         check("pop", {7'h00, pop}, {7'h00, i == 1});
         rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      end
      // Error aggregation, only enabled sources count
      wr_reg(uif_pkg::ADDR_ERR_ENABLES, 8'h01);
      pulse(11'h004);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      pulse(11'h001);
      rd_reg(uif_pkg::ADDR_ERR_FLAGS, 8'h05);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h02);
      wr_reg(uif_pkg::ADDR_ERR_FLAGS, 8'h05);
      wr_reg(uif_pkg::ADDR_FLAGS, 8'h02);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      // Bus reset level, once per assertion
      se0 = 1'b1;
      hold(600);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      hold(40);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h01);
      wr_reg(uif_pkg::ADDR_FLAGS, 8'h01);
      hold(700);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h00);
      se0 = 1'b0;
      hold(10);
      se0 = 1'b1;
      hold(700);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h01);
      check("reset seen", {7'h00, seen}, 8'h01);
      se0 = 1'b0;
      wr_reg(uif_pkg::ADDR_FLAGS, 8'h01);
      k_st = 1'b1;
      hold(700);
      rd_reg(uif_pkg::ADDR_FLAGS, 8'h20);
      tally_and_finish();
   end
endmodule
`default_nettype wire
